//--- shared/line_code_if.sv
// Carrier between the channel top and its line encoder.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface line_code_if;
  logic stb;       // One-cycle pulse per captured bit.
  logic data_bit;  // Serial data bit taken from the positive rail.
  logic hdb3_sel;  // High selects four-zero substitution, low three-zero.
  logic pos;       // Encoded positive mark for the bit leaving the encoder.
  logic neg;       // Encoded negative mark for the bit leaving the encoder.

  modport encoder (input stb, input data_bit, input hdb3_sel, output pos, output neg);
  modport user (output stb, output data_bit, output hdb3_sel, input pos, input neg);
endinterface

`default_nettype wire

//--- shared/tx_line_params.svh
// Constants for the transmit line output channel.
// Assumes inclusion by bare name from any file of the block.
`ifndef TX_LINE_PARAMS_SVH
`define TX_LINE_PARAMS_SVH

// Flip-flops that a pin input passes before logic reads it.
`define SYNC_STAGES 2
// Zero run replaced by a substitution in each line code.
`define B3ZS_RUN 3
`define HDB3_RUN 4
// Reset value of the last sent polarity, negative, so the first mark goes out positive.
`define LAST_NEG_RESET 1'b1

`endif

//--- shared/tx_line_pkg.sv
// Types shared by the transmit line output channel.
// Assumes nothing of its surroundings.
package tx_line_pkg;

  // Pulse to be placed on the line for one bit period.
  typedef enum logic [1:0] {
    PULSE_NONE = 2'h0,
    PULSE_POS  = 2'h1,
    PULSE_NEG  = 2'h2
  } pulse_type;

endpackage

//--- src/line_encoder.sv
// Zero-substituting bipolar line encoder for single-rail data.
// Assumes one strobe per bit from the channel top on the same clock.
`timescale 1ns/1ps
`default_nettype none

`include "tx_line_params.svh"

module line_encoder import tx_line_pkg::*; (
  input wire logic   core_clk,  // Core clock.
  input wire logic   rst_b,     // Synchronous reset, active low.
  line_code_if.encoder lc       // Bit stream in, marks out.
);
  localparam int DEPTH = `HDB3_RUN;

  logic [DEPTH-1:0] mark_q;
  logic [DEPTH-1:0] mark_d;
  logic [DEPTH-1:0] viol_q;
  logic [DEPTH-1:0] viol_d;
  logic             parity_q;
  logic             last_neg_q;

  // The oldest bit sits at the end of the run length for the chosen code.
  wire [1:0] tail_idx     = lc.hdb3_sel ? 2'(`HDB3_RUN - 1) : 2'(`B3ZS_RUN - 1);
  wire       tail_mark    = mark_q[tail_idx];
  wire       tail_viol    = viol_q[tail_idx];
  wire       window_clear = lc.hdb3_sel ? ~|mark_q[2:0] : ~|mark_q[1:0];
  wire       subst        = ~lc.data_bit & window_clear;
  // Parity counts marks since the last violation, the leaving bit included.
  wire       parity_eff   = tail_viol ? 1'b0 : (parity_q ^ tail_mark);
  wire       need_b       = ~parity_eff;
  // A violation repeats the last polarity; any other mark alternates.
  wire       tail_neg     = tail_viol ? last_neg_q : ~last_neg_q;

  assign lc.pos = tail_mark & ~tail_neg;
  assign lc.neg = tail_mark & tail_neg;

  // Shift in the new bit and place substitution marks over a zero run.
  always_comb begin
    mark_d = {mark_q[DEPTH-2:0], lc.data_bit | subst};
    viol_d = {viol_q[DEPTH-2:0], subst};
    if (subst && need_b) begin
      mark_d[tail_idx] = 1'b1;
    end
  end

  // Advance once per bit.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mark_q     <= '0;
      viol_q     <= '0;
      parity_q   <= 1'b0;
      last_neg_q <= `LAST_NEG_RESET;
    end else if (lc.stb) begin
      mark_q     <= mark_d;
      viol_q     <= viol_d;
      parity_q   <= parity_eff;
      last_neg_q <= tail_mark ? tail_neg : last_neg_q;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_subst_violation: assert property (lc.stb && subst |=> viol_q[0] && mark_q[0])
    else $error("Zero run did not produce a violation mark.");
  a_subst_balance: assert property (lc.stb && subst && need_b && $stable(lc.hdb3_sel)
    |=> mark_q[tail_idx])
    else $error("Balancing mark missing from substitution.");
  a_marks_alternate: assert property (lc.stb && tail_mark && !tail_viol
    |=> last_neg_q != $past(last_neg_q))
    else $error("Ordinary marks did not alternate polarity.");
endmodule

`default_nettype wire

//--- src/tx_dual_rail_line_output.sv
// Transmit line output of one channel: rail capture, optional encoding, line drive.
// Assumes the framer clock and rails arrive asynchronously on pins, and that
// the core clock is fast enough to see every transmit clock edge.
`timescale 1ns/1ps
`default_nettype none

`include "tx_line_params.svh"

module tx_dual_rail_line_output import tx_line_pkg::*; (
  input  wire logic core_clk,               // Core clock, 40 MHz.
  input  wire logic rst_b,                  // Synchronous reset, active low.
  input  wire logic tx_sample_clock_ch,     // Transmit clock from the framer.
  input  wire logic tx_positive_rail_in_ch, // Positive rail or serial data.
  input  wire logic tx_negative_rail_in_ch, // Negative rail, unused in single-rail.
  input  wire logic transmitter_on,         // Transmitter-on pin.
  input  wire logic transmitter_on_cfg,     // Transmitter-on control bit.
  input  wire logic single_rail_mode,       // High selects single-rail mode.
  input  wire logic hdb3_select,            // High selects the four-zero code.
  output logic      line_out_tip_ch,        // Tip drive level.
  output logic      line_out_tip_oe_ch,     // Tip output enable.
  output logic      line_out_ring_ch,       // Ring drive level.
  output logic      line_out_ring_oe_ch     // Ring output enable.
);
  // Number of pins that pass the common synchroniser.
  localparam int NPIN = 7;

  // Pin inputs gathered for a common two-stage synchroniser.
  wire [NPIN-1:0] pins_raw = {hdb3_select, single_rail_mode, transmitter_on_cfg,
                              transmitter_on, tx_negative_rail_in_ch,
                              tx_positive_rail_in_ch, tx_sample_clock_ch};
  // Synchroniser stages, edge history, captured rails and line state.
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  logic            clk_prev_q;
  logic            pos_cap_q;
  logic            neg_cap_q;
  pulse_type       pulse_q;
  pulse_type       pulse_d;
  logic            tip_q;
  logic            ring_q;
  logic            tip_oe_q;
  logic            ring_oe_q;

  line_code_if lc ();

  // Two flip-flops per pin; only the second stage is read by logic.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pins_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins.
  wire clk_s    = sync_q[0];
  wire pos_s    = sync_q[1];
  wire neg_s    = sync_q[2];
  wire on_s     = sync_q[3] & sync_q[4];
  wire single_s = sync_q[5];
  wire hdb3_s   = sync_q[6];

  // Active edge of the transmit clock is its rising edge.
  // History resets low, the idle level of the pin, so reset makes no false edge.
  wire edge_w   = clk_s & ~clk_prev_q;

  // Encoder carries single-rail data; the negative rail never reaches it.
  assign lc.stb      = edge_w & single_s;
  assign lc.data_bit = pos_s;
  assign lc.hdb3_sel = hdb3_s;

  // The encoder runs on the same clock and reset as the channel.
  line_encoder u_encoder (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .lc       (lc.encoder)
  );

  // Rails as sampled on the edge; the same values feed the drive decision.
  wire dual_pos = pos_s & ~neg_s;
  wire dual_neg = neg_s & ~pos_s;

  // Pulse for the coming bit: encoder marks or raw rails, never both.
  always_comb begin
    pulse_d = PULSE_NONE;
    if (single_s) begin
      if (lc.pos) begin
        pulse_d = PULSE_POS;
      end else if (lc.neg) begin
        pulse_d = PULSE_NEG;
      end
    end else if (dual_pos) begin
      pulse_d = PULSE_POS;
    end else if (dual_neg) begin
      pulse_d = PULSE_NEG;
    end
  end

  // Edge detector history and rail capture.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_prev_q <= 1'b0;
      pos_cap_q  <= 1'b0;
      neg_cap_q  <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
      if (edge_w) begin
        pos_cap_q <= pos_s;
        neg_cap_q <= neg_s;
      end
    end
  end

  // The chosen pulse stands for one whole bit period.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_q <= PULSE_NONE;
    end else if (edge_w) begin
      pulse_q <= pulse_d;
    end
  end

  // Line drive: tip over ring for positive, ring over tip for negative.
  wire tip_d  = on_s & (pulse_q == PULSE_POS);
  wire ring_d = on_s & (pulse_q == PULSE_NEG);

  // Output flip-flops; enables drop while the transmitter is off.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tip_q     <= 1'b0;
      ring_q    <= 1'b0;
      tip_oe_q  <= 1'b0;
      ring_oe_q <= 1'b0;
    end else begin
      tip_q     <= tip_d;
      ring_q    <= ring_d;
      tip_oe_q  <= on_s;
      ring_oe_q <= on_s;
    end
  end

  // Outputs come straight from their flip-flops.
  assign line_out_tip_ch     = tip_q;
  assign line_out_ring_ch    = ring_q;
  assign line_out_tip_oe_ch  = tip_oe_q;
  assign line_out_ring_oe_ch = ring_oe_q;

  // Checks below sample on the core clock and stay quiet while reset is held.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Rail capture happens on the active transmit edge and nowhere between edges.
  a_neg_rail_capture: assert property (edge_w |=> neg_cap_q == $past(neg_s))
    else $error("Negative rail not captured on the transmit edge.");
  a_pos_rail_capture: assert property (edge_w |=> pos_cap_q == $past(pos_s))
    else $error("Positive rail not captured on the transmit edge.");
  a_neg_cap_hold: assert property (!edge_w |=> $stable(neg_cap_q))
    else $error("Negative rail capture changed between transmit edges.");
  a_pos_cap_hold: assert property (!edge_w |=> $stable(pos_cap_q))
    else $error("Positive rail capture changed between transmit edges.");
  a_pulse_holds: assert property (!edge_w |=> $stable(pulse_q))
    else $error("Pulse choice changed inside a bit period.");

  // Single-rail mode: only encoder marks reach the line, never the negative rail.
  a_single_ignores_neg: assert property (edge_w && single_s && !lc.neg
    |=> pulse_q != PULSE_NEG)
    else $error("Negative rail reached the line in single-rail mode.");
  a_single_pos_drive: assert property (edge_w && single_s && lc.pos
    ##1 on_s |=> tip_q && !ring_q)
    else $error("Encoded positive mark did not put tip above ring.");
  a_single_neg_drive: assert property (edge_w && single_s && lc.neg
    ##1 on_s |=> !tip_q && ring_q)
    else $error("Encoded negative mark did not put ring above tip.");

  // Dual-rail mode: the sampled rails drive the line without coding.
  a_dual_pos_drive: assert property (edge_w && !single_s && dual_pos
    ##1 on_s |=> tip_q && !ring_q)
    else $error("Positive request did not put tip above ring.");
  a_dual_neg_drive: assert property (edge_w && !single_s && dual_neg
    ##1 on_s |=> !tip_q && ring_q)
    else $error("Negative request did not put ring above tip.");
  a_dual_unencoded: assert property (edge_w && !single_s |=> pulse_q ==
    (($past(dual_pos)) ? PULSE_POS : ($past(dual_neg) ? PULSE_NEG : PULSE_NONE)))
    else $error("Dual-rail pulse differs from the sampled rails.");
  a_idle_equal: assert property (edge_w && !single_s && !pos_s && !neg_s
    ##1 1 |=> tip_q == ring_q)
    else $error("Line not at rest for an empty bit.");
  a_both_rails_rest: assert property (edge_w && !single_s && pos_s && neg_s
    ##1 1 |=> !tip_q && !ring_q)
    else $error("Both rails high did not leave the line at rest.");

  // Line drive safety and the transmitter-on gate.
  a_never_both_high: assert property (!(tip_q && ring_q))
    else $error("Tip and ring driven high together.");
  a_tip_needs_pulse: assert property (tip_q |-> $past(pulse_q) == PULSE_POS)
    else $error("Tip driven high without a positive pulse.");
  a_ring_needs_pulse: assert property (ring_q |-> $past(pulse_q) == PULSE_NEG)
    else $error("Ring driven high without a negative pulse.");
  a_off_tristate: assert property (!on_s |=> !tip_oe_q && !ring_oe_q && !tip_q && !ring_q)
    else $error("Line outputs enabled while transmitter is off.");
  a_on_enables: assert property (on_s |=> tip_oe_q && ring_oe_q)
    else $error("Line outputs not enabled while transmitter is on.");
endmodule

`default_nettype wire

//--- test/framer_model.sv
// Behavioural framer: transmit clock and both rails for one channel.
// Assumes the bench sets each request before the load point of the bit.
`timescale 1ns/1ps
`default_nettype none

module framer_model (
  input  wire logic core_clk, // Core clock that paces the model.
  input  wire logic run,      // High lets the transmit clock run.
  input  wire logic pos_req,  // Positive rail value for the next bit.
  input  wire logic neg_req,  // Negative rail value for the next bit.
  output logic      tx_clk,   // Transmit clock, still while idle.
  output logic      pos_rail, // Positive rail pin.
  output logic      neg_rail  // Negative rail pin.
);
  logic [3:0] cnt_q;

  // Rails start at opposite levels so an idle toggle never shows a stale value.
  initial begin
    pos_rail = 1'b0;
    neg_rail = 1'b1;
  end

  // Twelve core cycles a bit, six high; rails change mid low phase, far from the rise.
  always @(posedge core_clk) begin
    cnt_q <= !run ? 4'h6 : (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
    if (!run) begin
      pos_rail <= ~pos_rail;
      neg_rail <= ~neg_rail;
    end else if (cnt_q == 4'h8) begin
      pos_rail <= pos_req;
      neg_rail <= neg_req;
    end
  end

  // The clock stands low between frames.
  assign tx_clk = run && (cnt_q < 4'h6);
endmodule

`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the transmit line output channel.
// Assumes the framer model supplies transmit clock and rails.
`timescale 1ns/1ps
`default_nettype none

module testbench import tx_line_pkg::*;;
  logic core_clk    = 1'b0;
  logic rst_b       = 1'b0;
  logic single_rail = 1'b0;
  logic hdb3        = 1'b0;
  logic on_pin      = 1'b1;
  logic on_cfg      = 1'b1;
  logic run         = 1'b0;
  logic pos_req     = 1'b0;
  logic neg_req     = 1'b0;
  int   fails       = 0;
  int   compares    = 0;
  int   cycles      = 0;
  wire logic tx_clk, pos_rail, neg_rail, tip, tip_oe, ring, ring_oe;
  // Resolved line wires: a disabled driver leaves the wire floating.
  wire logic tip_w  = tip_oe ? tip : 1'bz;
  wire logic ring_w = ring_oe ? ring : 1'bz;

  always #12.5 core_clk = ~core_clk;

  framer_model framer (.core_clk(core_clk), .run(run), .pos_req(pos_req),
    .neg_req(neg_req), .tx_clk(tx_clk), .pos_rail(pos_rail), .neg_rail(neg_rail));

  tx_dual_rail_line_output DUT (.core_clk(core_clk), .rst_b(rst_b),
    .tx_sample_clock_ch(tx_clk), .tx_positive_rail_in_ch(pos_rail),
    .tx_negative_rail_in_ch(neg_rail), .transmitter_on(on_pin),
    .transmitter_on_cfg(on_cfg), .single_rail_mode(single_rail), .hdb3_select(hdb3),
    .line_out_tip_ch(tip), .line_out_tip_oe_ch(tip_oe), .line_out_ring_ch(ring),
    .line_out_ring_oe_ch(ring_oe));

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one line level, floating included.
  task automatic chk(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Checks tip and ring for one pulse kind.
  task automatic line_is(input pulse_type p);
    chk("tip", p == PULSE_POS, tip_w);
    chk("ring", p == PULSE_NEG, ring_w);
  endtask

  // Stops the framer clock and resets with the given mode selects.
  task automatic do_reset(input logic s, input logic h);
    @(posedge core_clk);
    rst_b       <= 1'b0;
    run         <= 1'b0;
    single_rail <= s;
    hdb3        <= h;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask

  // Sets both transmitter-on controls.
  task automatic set_on(input logic a, input logic b);
    @(posedge core_clk);
    on_pin <= a;
    on_cfg <= b;
  endtask

  // Sends one bit and returns five core cycles after its transmit clock rise.
  task automatic send(input logic p, input logic n);
    int k;
    k = 0;
    @(posedge core_clk);
    pos_req <= p;
    neg_req <= n;
    run     <= 1'b1;
    @(negedge core_clk);
    while (tx_clk !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 40) begin
      fails++;
      $display("mismatch tx_clk expected 1 seen %b", tx_clk);
    end
    repeat (5) @(negedge core_clk);
  endtask

  // Dual-rail pulses back to back, both rails, and idle bits.
  task automatic t_dual();
    send(1'b1, 1'b0);
    line_is(PULSE_POS);
    send(1'b1, 1'b0);
    line_is(PULSE_POS);
    send(1'b0, 1'b1);
    line_is(PULSE_NEG);
    send(1'b1, 1'b1);
    line_is(PULSE_NONE);
    send(1'b0, 1'b0);
    line_is(PULSE_NONE);
  endtask

  // Each transmitter-on control alone floats both line wires.
  task automatic t_off();
    set_on(1'b0, 1'b1);
    send(1'b1, 1'b0);
    chk("tip", 1'bz, tip_w);
    chk("ring", 1'bz, ring_w);
    set_on(1'b1, 1'b0);
    send(1'b0, 1'b1);
    chk("tip", 1'bz, tip_w);
    chk("ring", 1'bz, ring_w);
    set_on(1'b1, 1'b1);
    send(1'b0, 1'b1);
    line_is(PULSE_NEG);
  endtask

  // Single-rail serial data; the negative rail stands low for the three-zero code,
  // as the framer should keep it, and high for the four-zero code, which must be ignored.
  task automatic t_single(input logic h, input int lat, input logic [9:0] b,
                          input pulse_type e[6]);
    do_reset(1'b1, h);
    for (int k = 0; k < 10; k++) begin
      send(b[9-k], h);
      if (k >= lat && k - lat < 6) begin
        line_is(e[k-lat]);
      end
    end
  endtask

  // Cuts a hang short.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    do_reset(1'b0, 1'b0);
    t_dual();
    t_off();
    t_single(1'b0, 3, 10'b1000111111, '{PULSE_POS, PULSE_NONE, PULSE_NONE,
             PULSE_POS, PULSE_NEG, PULSE_POS});
    t_single(1'b1, 4, 10'b1000011111, '{PULSE_POS, PULSE_NONE, PULSE_NONE,
             PULSE_NONE, PULSE_POS, PULSE_NEG});
    end_of_test();
  end
endmodule

`default_nettype wire
